// File: verilog/fsps_pkg.sv
// Package: shared constants and types of the flash self-program sequencer
package fsps_pkg;
	// Control/status bit positions
	localparam int unsigned BIT_ENABLE = 0;
	localparam int unsigned BIT_ERASE = 1;
	localparam int unsigned BIT_WRITE = 2;
	localparam int unsigned BIT_LOCK = 3;
	localparam int unsigned BIT_REEN = 4;
	localparam int unsigned BIT_BUSY = 6;
	localparam int unsigned BIT_IRQEN = 7;
	// Valid low-five-bit command codes
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Arming window in clock cycles
	localparam logic [2:0] ARM_CYCLES = 3'h4;
	// Lock bits sit at data bits 5..2
	localparam int unsigned LOCK_LSB = 2;
	localparam logic [3:0] LOCK_RESET = 4'hf;
	// Flash operation time, microseconds, and clock rate in kHz
	localparam int unsigned PROG_TIME_US = 4500;
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_KHZ / 1000;
	typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_BUSY} fsps_state_t;
endpackage

// File: verilog/fsps_buf_if.sv
// Interface: page buffer write and clear path
interface fsps_buf_if #(parameter int WIDX = 6);
	logic wr;
	logic clr;
	logic [WIDX-1:0] idx;
	logic [15:0] data;
	modport ctrl (output wr, output clr, output idx, output data);
	modport buffer (input wr, input clr, input idx, input data);
endinterface

// File: verilog/fsps_page_buf.sv
// Temporary page buffer, flip-flop storage cleared to all ones
module fsps_page_buf
	import fsps_pkg::*;
#(
	parameter int WIDX = 6
) (
	input wire logic mclk,
	input wire logic reset,
	fsps_buf_if.buffer bus,
	input wire logic [WIDX-1:0] rd_idx,
	output logic [15:0] rd_data
);
	logic [15:0] mem_reg [2**WIDX];
	// Each word loads on its index; clear returns it to erased state
	genvar g;
	generate
		for (g = 0; g < 2**WIDX; g++) begin : g_word
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					mem_reg[g] <= 16'hffff;
				end else if (bus.clr) begin
					mem_reg[g] <= 16'hffff;
				end else if (bus.wr && bus.idx == WIDX'(g)) begin
					mem_reg[g] <= bus.data;
				end
			end
		end
	endgenerate
	// Registered read port for the flash programming engine
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_data <= 16'hffff;
		end else begin
			rd_data <= mem_reg[rd_idx];
		end
	end
endmodule

// File: verilog/fsps_timer.sv
// Operation timer: counts a flash operation and pulses done
module fsps_timer #(
	parameter int unsigned CYCLES = 180000
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	output logic running,
	output logic done
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_reg;
	// Start loads the count; done pulses as it reaches zero
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_reg <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_reg <= W'(CYCLES);
			end else if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - 1'b1;
				done <= (cnt_reg == W'(1));
			end
		end
	end
	assign running = (cnt_reg != '0);
endmodule

// File: verilog/fsps_seq.sv
// Flash self-program sequencer: command arming, buffer load, erase/write, lock set
// Notes on behaviour
// RQ1: Enable bit arms store-program four cycles; clears on completion or timeout.
// RQ2: Enable alone loads data word into page buffer at pointer, ignoring bit 0.
// RQ3: Enable stays set through erase or write until the operation finishes.
// RQ4: Only five low-bit command patterns are accepted; others do nothing.
// RQ5: Flash address latched at operation start; later pointer changes ignored.
// RQ6: Lock-bit set ignores the pointer; other commands use it.
// RQ7: Program-memory reads address bytes, pointer bit 0 picks the byte.
// RQ8: Erase code plus store-program erases page given by page index bits.
// RQ9: Concurrent-section ops keep other section readable; halting-section ops halt CPU.
// RQ10: Load code plus store-program writes buffer at word-index bits.
// RQ11: Buffer clears after page write, on re-enable write, and on reset.
// RQ12: Software writes each buffer word once between clears.
// RQ13: EEPROM write during buffer loading discards all loaded data.
// RQ14: Write code plus store-program programs buffer into indexed page.
// RQ15: With interrupt enabled, request stays high while enable bit is clear.
// RQ16: Erase or write blocks concurrent section; busy flag holds meanwhile.
// RQ17: Software clears busy via re-enable before touching that section again.
// RQ18: Lock code plus store-program sets lock bits from low data byte.
// RQ19: Data bits 5..2 that are zero program the matching lock bits.
// RQ20: Software should use pointer 0x0001 and ones in spare data bits.
// RQ21: EEPROM write in progress blocks programming commands and lock readback.
// RQ22: Software checks EEPROM pending flag before writing control register.
// RQ23: Re-enable plus store-program unblocks section; refused while flash busy.
// RQ24: Re-enable write during buffer loading aborts load and drops data.
// RQ25: Busy set when section erase or write starts; cleared by buffer load.
// RQ26: Window counts from the write's cycle; command bits clear on expiry.
module fsps_seq
	import fsps_pkg::*;
#(
	parameter int WIDX = 6,
	parameter int PIDX = 7,
	parameter int unsigned RWW_PAGES = 96,
	parameter int unsigned OP_CYCLES = PROG_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	output logic [7:0] self_prog_ctrl_status,
	input wire logic spm_exec,
	input wire logic lpm_exec,
	input wire logic [15:0] pointer,
	input wire logic [7:0] data_low_reg,
	input wire logic [7:0] data_high_reg,
	input wire logic eeprom_write_pending,
	output logic spm_irq,
	output logic cpu_halt,
	output logic rww_read_block,
	output logic lock_read_sel,
	output logic [15:0] byte_addr,
	output logic [3:0] lock_bits,
	output logic flash_erase,
	output logic flash_write,
	output logic [PIDX-1:0] flash_page,
	output logic [WIDX-1:0] flash_word_idx,
	output logic [15:0] flash_word_data
);
	fsps_buf_if #(.WIDX(WIDX)) buf_bus ();

	fsps_state_t state_reg;
	logic [4:0] cmd_reg;
	logic prog_done_irq_enable_reg;
	logic section_busy_flag_reg;
	logic [2:0] arm_cnt_reg;
	logic [PIDX-1:0] page_reg;
	logic op_erase_reg;
	logic op_halt_reg;
	logic loading_reg;
	logic timer_start;
	logic timer_running;
	logic timer_done;
	logic cmd_valid;
	logic spm_fire;
	logic lpm_lock;
	logic [WIDX-1:0] rd_idx;

	// Recognise a legal command code in the low five bits
	function automatic logic is_cmd(input logic [4:0] c);
		return c == CMD_LOAD || c == CMD_ERASE || c == CMD_WRITE ||
			c == CMD_LOCK || c == CMD_REEN;
	endfunction

	// Page-index field of the pointer, above the word-index bits
	function automatic logic [PIDX-1:0] page_of(input logic [15:0] p);
		return p[WIDX+PIDX:WIDX+1];
	endfunction

	// A control write only counts with a legal code and no EEPROM write
	assign cmd_valid = ctrl_wr && is_cmd(ctrl_wdata[4:0]) && state_reg != FSPS_BUSY
		&& !eeprom_write_pending; // [RQ4] [RQ21]
	// Store-program accepted only inside the arming window
	assign spm_fire = spm_exec && state_reg == FSPS_ARMED && !eeprom_write_pending; // [RQ1] [RQ21]
	// Lock readback within the window, blocked by EEPROM writes
	assign lpm_lock = lpm_exec && state_reg == FSPS_ARMED && cmd_reg == CMD_LOCK
		&& !eeprom_write_pending; // [RQ21]

	// Interrupt-enable bit is plain storage; any control write updates it
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prog_done_irq_enable_reg <= CTRL_RESET[BIT_IRQEN];
		end else if (ctrl_wr) begin
			prog_done_irq_enable_reg <= ctrl_wdata[BIT_IRQEN];
		end
	end

	// Command state: armed window, running operation, idle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= FSPS_IDLE;
			cmd_reg <= CTRL_RESET[4:0];
			arm_cnt_reg <= 3'h0;
		end else begin
			case (state_reg)
				FSPS_IDLE, FSPS_ARMED: begin
					if (cmd_valid) begin
						state_reg <= FSPS_ARMED;
						cmd_reg <= ctrl_wdata[4:0];
						arm_cnt_reg <= ARM_CYCLES - 3'h1; // [RQ26]
					end else if (spm_fire) begin
						if (cmd_reg == CMD_ERASE || cmd_reg == CMD_WRITE ||
							cmd_reg == CMD_LOCK) begin
							state_reg <= FSPS_BUSY; // [RQ3]
						end else begin
							state_reg <= FSPS_IDLE; // [RQ1]
							cmd_reg <= 5'h00;
						end
					end else if (lpm_lock) begin
						state_reg <= FSPS_IDLE;
						cmd_reg <= 5'h00;
					end else if (state_reg == FSPS_ARMED) begin
						if (arm_cnt_reg == 3'h0) begin
							state_reg <= FSPS_IDLE; // [RQ1] [RQ26]
							cmd_reg <= 5'h00;
						end else begin
							arm_cnt_reg <= arm_cnt_reg - 3'h1;
						end
					end
				end
				FSPS_BUSY: begin
					// Enable and command bits hold until the flash is done
					if (timer_done) begin
						state_reg <= FSPS_IDLE; // [RQ3]
						cmd_reg <= 5'h00;
					end
				end
				default: begin
					state_reg <= FSPS_IDLE;
					cmd_reg <= 5'h00;
				end
			endcase
		end
	end

	// Operation start latches page and section; pointer is free afterwards
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			page_reg <= '0;
			op_erase_reg <= 1'b0;
			op_halt_reg <= 1'b0;
		end else if (spm_fire && (cmd_reg == CMD_ERASE || cmd_reg == CMD_WRITE)) begin
			page_reg <= page_of(pointer); // [RQ5] [RQ8] [RQ14]
			op_erase_reg <= (cmd_reg == CMD_ERASE);
			op_halt_reg <= (32'(page_of(pointer)) >= RWW_PAGES); // [RQ9]
		end else if (spm_fire && cmd_reg == CMD_LOCK) begin
			op_erase_reg <= 1'b0;
			op_halt_reg <= 1'b0; // [RQ18]
		end
	end

	// Lock bits: each zero in data bits 5..2 programs its bit, pointer unused
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lock_bits <= LOCK_RESET;
		end else if (spm_fire && cmd_reg == CMD_LOCK) begin
			lock_bits <= lock_bits & data_low_reg[LOCK_LSB+3:LOCK_LSB]; // [RQ6] [RQ19]
		end
	end

	// Busy flag: set at section erase/write start, cleared by re-enable or load
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			section_busy_flag_reg <= 1'b0;
		end else if (spm_fire && (cmd_reg == CMD_ERASE || cmd_reg == CMD_WRITE)
			&& 32'(page_of(pointer)) < RWW_PAGES) begin
			section_busy_flag_reg <= 1'b1; // [RQ25] [RQ16]
		end else if (spm_fire && (cmd_reg == CMD_REEN || cmd_reg == CMD_LOAD)) begin
			section_busy_flag_reg <= 1'b0; // [RQ23] [RQ25]
		end
	end

	// Loading marks buffer contents worth discarding
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			loading_reg <= 1'b0;
		end else if (buf_bus.clr) begin
			loading_reg <= 1'b0;
		end else if (spm_fire && cmd_reg == CMD_LOAD) begin
			loading_reg <= 1'b1;
		end
	end

	// Buffer write path takes word index, skipping pointer bit 0
	assign buf_bus.wr = spm_fire && cmd_reg == CMD_LOAD; // [RQ2] [RQ10]
	assign buf_bus.idx = pointer[WIDX:1]; // [RQ2]
	assign buf_bus.data = {data_high_reg, data_low_reg};
	// Clear after write, on re-enable write, or EEPROM write during load
	assign buf_bus.clr = timer_done && !op_erase_reg && state_reg == FSPS_BUSY
		&& cmd_reg == CMD_WRITE // [RQ11]
		|| (cmd_valid && ctrl_wdata[BIT_REEN]) // [RQ4] [RQ11] [RQ24]
		|| (eeprom_write_pending && loading_reg); // [RQ13]

	assign timer_start = spm_fire && (cmd_reg == CMD_ERASE || cmd_reg == CMD_WRITE
		|| cmd_reg == CMD_LOCK);

	fsps_timer #(.CYCLES(OP_CYCLES)) u_timer (
		.mclk(mclk),
		.reset(reset),
		.start(timer_start),
		.running(timer_running),
		.done(timer_done)
	);

	// Engine walks the buffer while a page write runs
	assign rd_idx = flash_word_idx;

	fsps_page_buf #(.WIDX(WIDX)) u_buf (
		.mclk(mclk),
		.reset(reset),
		.bus(buf_bus),
		.rd_idx(rd_idx),
		.rd_data(flash_word_data)
	);

	// Word index steps through the page during a write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flash_word_idx <= '0;
		end else if (timer_start) begin
			flash_word_idx <= '0;
		end else if (flash_write) begin
			flash_word_idx <= flash_word_idx + 1'b1;
		end
	end

	// Strobes to the flash array, from the latched page
	assign flash_erase = state_reg == FSPS_BUSY && cmd_reg == CMD_ERASE && timer_running;
	assign flash_write = state_reg == FSPS_BUSY && cmd_reg == CMD_WRITE && timer_running;
	assign flash_page = page_reg; // [RQ5]

	// Halt CPU only for non-concurrent section operations
	assign cpu_halt = state_reg == FSPS_BUSY && op_halt_reg
		&& (cmd_reg == CMD_ERASE || cmd_reg == CMD_WRITE); // [RQ9]
	// Concurrent section stays blocked until a re-enable or load clears the busy flag
	assign rww_read_block = section_busy_flag_reg
		|| (state_reg == FSPS_BUSY && cmd_reg != CMD_LOCK); // [RQ16]

	// Byte address for program-memory reads uses all pointer bits
	assign byte_addr = pointer; // [RQ7]
	assign lock_read_sel = lpm_lock;

	// Level request while enabled and idle
	assign spm_irq = prog_done_irq_enable_reg && state_reg == FSPS_IDLE; // [RQ15]

	// Status image: reserved bit 5 reads zero
	always_comb begin
		self_prog_ctrl_status = 8'h00;
		self_prog_ctrl_status[BIT_IRQEN] = prog_done_irq_enable_reg;
		self_prog_ctrl_status[BIT_BUSY] = section_busy_flag_reg;
		self_prog_ctrl_status[4:0] = (state_reg == FSPS_IDLE) ? 5'h00 : cmd_reg;
	end
endmodule

// File: tb/fsps_seq_chk.sv
// Checker: port-level properties of the flash self-program sequencer
module fsps_seq_chk
	import fsps_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] self_prog_ctrl_status,
	input wire logic spm_exec,
	input wire logic lpm_exec,
	input wire logic cpu_halt,
	input wire logic lock_read_sel,
	input wire logic [15:0] pointer,
	input wire logic eeprom_write_pending,
	input wire logic spm_irq,
	input wire logic rww_read_block,
	input wire logic [15:0] byte_addr,
	input wire logic flash_erase,
	input wire logic flash_write
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic idle;
	logic legal;
	// Idle: nothing armed or running; legal: one of the five accepted codes
	assign idle = self_prog_ctrl_status[4:0] == 5'h00;
	assign legal = ctrl_wdata[4:0] inside {CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN};
	a_arm_expiry: assert property (
		ctrl_wr && legal && idle && !eeprom_write_pending ##1 (!spm_exec && !ctrl_wr) [*4]
		|=> idle) else $error("arming window did not expire");
	a_cmd_taken: assert property (
		ctrl_wr && legal && idle && !eeprom_write_pending
		|=> self_prog_ctrl_status[4:0] == $past(ctrl_wdata[4:0])) else $error("command not taken");
	a_bad_code: assert property (ctrl_wr && !legal && idle |=> idle)
		else $error("illegal code had an effect");
	a_eeprom_block: assert property (ctrl_wr && eeprom_write_pending && idle |=> idle)
		else $error("command taken during eeprom write");
	a_irq_level: assert property (
		spm_irq == (self_prog_ctrl_status[7] && !self_prog_ctrl_status[0]))
		else $error("interrupt request level wrong");
	a_op_enable: assert property ((flash_erase || flash_write) |-> self_prog_ctrl_status[0])
		else $error("enable dropped during operation");
	a_spm_erase: assert property (
		self_prog_ctrl_status[4:0] == CMD_ERASE && spm_exec && !eeprom_write_pending
		&& !rww_read_block |=> flash_erase)
		else $error("erase did not start");
	a_load_done: assert property (
		self_prog_ctrl_status[4:0] == CMD_LOAD && spm_exec && !ctrl_wr
		&& !eeprom_write_pending |=> idle)
		else $error("load left enable set");
	a_read_block: assert property ((flash_erase || flash_write) |-> rww_read_block)
		else $error("section readable during operation");
	a_byte_addr: assert property (byte_addr == pointer)
		else $error("byte address differs from pointer");
	// Lock readback only inside a lock window and never during an EEPROM write
	a_lock_read: assert property (
		lock_read_sel |-> lpm_exec && self_prog_ctrl_status[4:0] == CMD_LOCK
		&& !eeprom_write_pending) else $error("lock readback outside its window");
	a_halt_scope: assert property (
		cpu_halt |-> self_prog_ctrl_status[0] && self_prog_ctrl_status[2:1] != 2'b00)
		else $error("cpu halted outside erase or write");
endmodule

bind fsps_seq fsps_seq_chk chk (.mclk, .reset, .ctrl_wr, .ctrl_wdata, .self_prog_ctrl_status,
	.spm_exec, .lpm_exec, .cpu_halt, .lock_read_sel, .pointer, .eeprom_write_pending,
	.spm_irq, .rww_read_block, .byte_addr,
	.flash_erase, .flash_write);

// File: tb/fsps_cpu_model.sv
// CPU core model: control writes followed by store-program or load instructions
module fsps_cpu_model (
	input wire logic mclk,
	input wire logic eeprom_write_pending,
	output logic ctrl_wr,
	output logic [7:0] ctrl_wdata,
	output logic spm_exec,
	output logic lpm_exec,
	output logic [15:0] pointer,
	output logic [7:0] data_low_reg,
	output logic [7:0] data_high_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ctrl_wr = 1'b0;
		ctrl_wdata = 8'h00;
		spm_exec = 1'b0;
		lpm_exec = 1'b0;
		pointer = 16'h0000;
		{data_high_reg, data_low_reg} = 16'h0000;
	end
	// One control write, then op: 0 nothing, 1 store-program, 2 load; ee_ok skips the wait
	task automatic cmd(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d,
		input logic [1:0] op, input logic ee_ok);
		@(negedge mclk);
		while (eeprom_write_pending && !ee_ok) @(negedge mclk);
		pointer = p;
		{data_high_reg, data_low_reg} = d;
		ctrl_wr = 1'b1;
		ctrl_wdata = c;
		@(negedge mclk);
		ctrl_wr = 1'b0;
		spm_exec = op[0];
		lpm_exec = op[1];
		@(negedge mclk);
		spm_exec = 1'b0;
		lpm_exec = 1'b0;
		// Pointer and data are reused at once, so a missing address latch shows up
		pointer = ~p;
		{data_high_reg, data_low_reg} = ~d;
	endtask
endmodule

// File: tb/tb.sv
// Testbench: command sequences against the flash self-program sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fsps_pkg::*;
	localparam int unsigned OPC = 20;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic ee = 1'b0;
	logic ctrl_wr, spm_exec, lpm_exec, spm_irq, cpu_halt, rblock, lsel, ferase, fwrite;
	logic [7:0] ctrl_wdata, status, dlo, dhi;
	logic [15:0] pointer, byte_addr, word_data;
	logic [3:0] lock_bits;
	logic [6:0] page;
	logic [5:0] widx;
	logic [7:0] bad [4] = '{8'h82, 8'h87, 8'h9f, 8'h93};
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	logic lsel_seen = 1'b0;
	// 40 MHz clock
	always #12.5 mclk = ~mclk;
	// Lock readback strobe lasts one cycle, so remember that it was seen
	always @(posedge mclk) begin
		if (lsel === 1'b1) begin
			lsel_seen <= 1'b1;
		end
	end
	fsps_seq #(.OP_CYCLES(OPC)) dut (.mclk(mclk), .reset(reset), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .self_prog_ctrl_status(status), .spm_exec(spm_exec),
		.lpm_exec(lpm_exec), .pointer(pointer), .data_low_reg(dlo), .data_high_reg(dhi),
		.eeprom_write_pending(ee), .spm_irq(spm_irq), .cpu_halt(cpu_halt),
		.rww_read_block(rblock), .lock_read_sel(lsel), .byte_addr(byte_addr),
		.lock_bits(lock_bits), .flash_erase(ferase), .flash_write(fwrite), .flash_page(page),
		.flash_word_idx(widx), .flash_word_data(word_data));
	fsps_cpu_model cpu (.mclk(mclk), .eeprom_write_pending(ee), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .spm_exec(spm_exec), .lpm_exec(lpm_exec), .pointer(pointer),
		.data_low_reg(dlo), .data_high_reg(dhi));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for the enable bit to drop after an erase or write
	task automatic wait_idle();
		int i;
		i = 0;
		while (status[0] !== 1'b0 && i < 4 * OPC) begin
			@(negedge mclk);
			i++;
		end
	endtask
	task automatic complete_run();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles >= 3000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		check(status, 16'h0000);
		check(lock_bits, 16'h000f);
		// Interrupt enable alone is stored, code ignored
		cpu.cmd(8'h80, 16'h0000, 16'h0000, 2'd0, 1'b0);
		check(status, 16'h0080);
		check(spm_irq, 16'h0001);
		foreach (bad[i]) begin
			cpu.cmd(bad[i], 16'h0000, 16'h5555, 2'd1, 1'b0);
			check(status, 16'h0080);
		end
		// Arm a load and let the window run out
		cpu.cmd(8'h81, 16'h0000, 16'h0000, 2'd0, 1'b0);
		check(spm_irq, 16'h0000);
		repeat (2) @(negedge mclk);
		check(status, 16'h0081);
		repeat (2) @(negedge mclk);
		check(status, 16'h0080);
		cpu.cmd(8'h81, 16'h0006, 16'h1234, 2'd1, 1'b0);
		check(status, 16'h0080);
		// Erase of a concurrently readable page, pointer scrambled meanwhile
		cpu.cmd(8'h83, 16'h0100, 16'h0000, 2'd1, 1'b0);
		check({ferase, cpu_halt, rblock}, 16'h0005);
		check(page, 16'h0002);
		check(status, 16'h00c3);
		cpu.cmd(8'h91, 16'h0000, 16'h0000, 2'd1, 1'b0);
		check(status, 16'h00c3);
		wait_idle();
		check({status, 7'h00, spm_irq}, 16'hc001);
		cpu.cmd(8'h91, 16'h0000, 16'h0000, 2'd1, 1'b0);
		check({status, 7'h00, rblock}, 16'h8000);
		// Erase of a page in the halting section
		cpu.cmd(8'h03, 16'h3200, 16'h0000, 2'd1, 1'b0);
		check({ferase, cpu_halt}, 16'h0003);
		check(page, 16'h0064);
		wait_idle();
		// Load then page write; a later load clears the busy flag
		cpu.cmd(8'h01, 16'h0002, 16'h00aa, 2'd1, 1'b0);
		cpu.cmd(8'h93, 16'h0000, 16'h0000, 2'd0, 1'b0);
		cpu.cmd(8'h05, 16'h0280, 16'h0000, 2'd1, 1'b0);
		check({fwrite, rblock}, 16'h0003);
		check({status, 1'b0, page}, 16'h4505);
		repeat (2) @(negedge mclk);
		check(word_data, 16'h00aa);
		check(widx, 16'h0002);
		repeat (2) @(negedge mclk);
		check(word_data, 16'hffff);
		wait_idle();
		check(status, 16'h0040);
		cpu.cmd(8'h01, 16'h0002, 16'h0055, 2'd1, 1'b0);
		check(status, 16'h0000);
		// Commands are refused while an EEPROM write runs
		ee = 1'b1;
		cpu.cmd(8'h83, 16'h0100, 16'h0000, 2'd1, 1'b1);
		check({status, 7'h00, ferase}, 16'h8000);
		ee = 1'b0;
		cpu.cmd(8'h05, 16'h0280, 16'h0000, 2'd1, 1'b0);
		repeat (2) @(negedge mclk);
		check(word_data, 16'hffff);
		wait_idle();
		// Lock bits: zeros in data bits 5..2 program, ones leave them
		cpu.cmd(8'h09, 16'h0001, 16'h00eb, 2'd1, 1'b0);
		check({ferase, fwrite, cpu_halt}, 16'h0000);
		wait_idle();
		check(lock_bits, 16'h000a);
		cpu.cmd(8'h09, 16'hffff, 16'h00ff, 2'd1, 1'b0);
		wait_idle();
		check(lock_bits, 16'h000a);
		// Lock readback ends the window; byte address follows the pointer
		cpu.cmd(8'h09, 16'h0001, 16'h0000, 2'd2, 1'b0);
		check(status, 16'h0040);
		check(lsel_seen, 16'h0001);
		check(byte_addr, 16'hfffe);
		check(lock_bits, 16'h000a);
		complete_run();
	end
endmodule
